// ### rtl/ep_status_top.sv
// endpoint status, fifo access flag and flag clear register over apb
// assumes link events are synchronous to pclk, apb master per protocol
//
// Our own choice: the APB register port.
`timescale 1ns/1ps
`include "ep_status_map.svh"

module ep_status_top
  import ep_status_pkg::*;
(
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // usb engine events
  input wire link_evt_t link_in,
  // endpoint state
  output logic [`EP_NFLAGS-1:0] endpoint_flag_status,
  output logic [1:0] current_bank_index,
  output logic fifo_access_allowed,
  output logic control_data_direction,
  output logic irq
);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  apb_state_t state_q, state_d;
  ep_cfg_t cfg_q, cfg_d;
  logic [31:0] prdata_q, prdata_d;
  logic pready_q, pready_d;
  logic pslverr_q, pslverr_d;
  logic [`EP_NFLAGS-1:0] irq_en_q, irq_en_d;
  logic [`EP_NFLAGS-1:0] flags_q;
  logic [1:0] bank_q, bank_d;
  logic switch_q, switch_d;
  logic fifo_access_allowed_q, fifo_access_allowed_d;
  logic control_data_direction_q, control_data_direction_d;
  logic irq_q, irq_d;

  // ----------------------------------------------------------------
  // apb decode
  // ----------------------------------------------------------------
  wire apb_setup = psel && !penable;
  wire apb_done = psel && penable && pready_q;
  wire wr_done = apb_done && pwrite;
  wire hit_cfg = (paddr == `EP_ADDR_CFG);
  wire hit_status = (paddr == `EP_ADDR_STATUS);
  wire hit_clr = (paddr == `EP_ADDR_FLAG_CLEAR);
  wire hit_en = (paddr == `EP_ADDR_IRQ_EN);
  wire hit_any = hit_cfg || hit_status || hit_clr || hit_en;
  wire kind_is_ctrl = (cfg_q.endpoint_kind == `EP_KIND_CONTROL);
  wire kind_clr_ok = kind_is_ctrl ||
    (cfg_q.endpoint_kind == `EP_KIND_BULK) ||
    (cfg_q.endpoint_kind == `EP_KIND_INTR);
  wire clr_wr = wr_done && hit_clr && kind_clr_ok;
  // bit i of the write clears flag i, except on isochronous endpoints
  wire [`EP_NFLAGS-1:0] clr_req = clr_wr ? pwdata[`EP_FLAGS] :
    `EP_ZERO8;

  // ----------------------------------------------------------------
  // read data
  // ----------------------------------------------------------------
  wire [31:0] rd_cfg = {18'h00000, cfg_q.nbank, 2'h0,
    cfg_q.stall_handshake_request, cfg_q.dir_in, 6'h00,
    cfg_q.endpoint_kind};
  wire [31:0] rd_status = {12'h000, control_data_direction_q, fifo_access_allowed_q, bank_q,
    8'h00, flags_q};
  wire [31:0] rd_en = {24'h000000, irq_en_q};
  wire [31:0] rd_data = hit_cfg ? rd_cfg :
    hit_status ? rd_status :
    hit_en ? rd_en :
    `EP_ZERO32;

  // ----------------------------------------------------------------
  // apb handshake
  // ----------------------------------------------------------------
  always_comb begin
    state_d = state_q;
    prdata_d = prdata_q;
    pready_d = pready_q;
    pslverr_d = pslverr_q;
    case (state_q)
      APB_IDLE: begin
        if (apb_setup) begin
          state_d = APB_RESP;
          pready_d = 1'b1;
          pslverr_d = !hit_any;
          prdata_d = pwrite ? `EP_ZERO32 : rd_data;
        end
      end
      APB_RESP: begin
        if (apb_done) begin
          state_d = APB_IDLE;
          pready_d = 1'b0;
          pslverr_d = 1'b0;
          prdata_d = `EP_ZERO32;
        end
      end
      default: begin
        state_d = APB_IDLE;
        pready_d = 1'b0;
        pslverr_d = 1'b0;
        prdata_d = `EP_ZERO32;
      end
    endcase
  end

  // ----------------------------------------------------------------
  // software registers
  // ----------------------------------------------------------------
  assign cfg_d = (wr_done && hit_cfg) ? '{
    endpoint_kind: pwdata[`EP_CFG_KIND],
    dir_in: pwdata[`EP_CFG_DIR_IN],
    stall_handshake_request: pwdata[`EP_CFG_STALL],
    nbank: pwdata[`EP_CFG_NBANK]} : cfg_q;
  assign irq_en_d = (wr_done && hit_en) ? pwdata[`EP_FLAGS] : irq_en_q;

  // ----------------------------------------------------------------
  // fifo access flag
  // ----------------------------------------------------------------
  wire access_block = cfg_q.stall_handshake_request || link_in.error;
  wire access_cond = cfg_q.dir_in ? link_in.bank_room :
    link_in.bank_data;
  assign fifo_access_allowed_d = !access_block && access_cond;

  // ----------------------------------------------------------------
  // current bank, one cycle behind the engine's switch
  // ----------------------------------------------------------------
  wire [1:0] bank_last = (cfg_q.nbank == 2'h0) ? `EP_BANK_0 :
    (cfg_q.nbank > 2'h2) ? `EP_BANK_2 :
    cfg_q.nbank - 2'h1;
  wire [1:0] bank_next = (bank_q >= bank_last) ? `EP_BANK_0 :
    bank_q + 2'h1;
  assign switch_d = link_in.bank_switch && !kind_is_ctrl;
  assign bank_d = kind_is_ctrl ? `EP_BANK_0 :
    switch_q ? bank_next : bank_q;

  // ----------------------------------------------------------------
  // control direction and interrupt
  // ----------------------------------------------------------------
  assign control_data_direction_d = link_in.setup_rx ? link_in.setup_dir_in :
    control_data_direction_q;
  assign irq_d = |(flags_q & irq_en_q);

  // ----------------------------------------------------------------
  // flags
  // ----------------------------------------------------------------
  ep_flag_bank #(
    .W(`EP_NFLAGS)
  ) u_flags (
    .pclk(pclk),
    .presetn(presetn),
    .set_evt(link_in.flag_set),
    .clr_req(clr_req),
    .flags_q(flags_q)
  );

  // ----------------------------------------------------------------
  // flip-flops
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q <= APB_IDLE;
      prdata_q <= `EP_ZERO32;
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
    end else begin
      state_q <= state_d;
      prdata_q <= prdata_d;
      pready_q <= pready_d;
      pslverr_q <= pslverr_d;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cfg_q <= '{endpoint_kind: `EP_KIND_CONTROL, dir_in: 1'b0,
        stall_handshake_request: 1'b0, nbank: `EP_NBANK_RST};
      irq_en_q <= `EP_ZERO8;
    end else begin
      cfg_q <= cfg_d;
      irq_en_q <= irq_en_d;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      bank_q <= `EP_BANK_0;
      switch_q <= 1'b0;
      fifo_access_allowed_q <= 1'b0;
      control_data_direction_q <= 1'b0;
      irq_q <= 1'b0;
    end else begin
      bank_q <= bank_d;
      switch_q <= switch_d;
      fifo_access_allowed_q <= fifo_access_allowed_d;
      control_data_direction_q <= control_data_direction_d;
      irq_q <= irq_d;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;
  assign endpoint_flag_status = flags_q;
  assign current_bank_index = bank_q;
  assign fifo_access_allowed = fifo_access_allowed_q;
  assign control_data_direction = control_data_direction_q;
  assign irq = irq_q;

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  property p_bank_legal;
    current_bank_index != `EP_BANK_RSVD;
  endproperty
  a_bank_legal: assert property (p_bank_legal)
    else $error("reserved bank code reported");

  property p_bank_ctrl;
    kind_is_ctrl |=> current_bank_index == `EP_BANK_0;
  endproperty
  a_bank_ctrl: assert property (p_bank_ctrl)
    else $error("control endpoint bank not zero");

  property p_bank_late;
    (link_in.bank_switch && !kind_is_ctrl && cfg_q.nbank == 2'h3 &&
      bank_q == `EP_BANK_0 && !switch_q && !(wr_done && hit_cfg)) ##1
      !(wr_done && hit_cfg) |->
      current_bank_index == `EP_BANK_0 ##1
      current_bank_index == `EP_BANK_1;
  endproperty
  a_bank_late: assert property (p_bank_late)
    else $error("bank did not advance one cycle late");

  property p_in_room;
    (!access_block && cfg_q.dir_in && link_in.bank_room) |=>
      fifo_access_allowed;
  endproperty
  a_in_room: assert property (p_in_room)
    else $error("in endpoint with room not allowed");

  property p_out_data;
    (!access_block && !cfg_q.dir_in) |=>
      fifo_access_allowed == $past(link_in.bank_data);
  endproperty
  a_out_data: assert property (p_out_data)
    else $error("out endpoint access flag wrong");

  property p_blocked;
    (cfg_q.stall_handshake_request || link_in.error) |=>
      !fifo_access_allowed;
  endproperty
  a_blocked: assert property (p_blocked)
    else $error("access allowed under stall or error");

  property p_dir_out;
    (link_in.setup_rx && !link_in.setup_dir_in) |=>
      !control_data_direction;
  endproperty
  a_dir_out: assert property (p_dir_out)
    else $error("direction not cleared for out");

  property p_dir_in;
    (link_in.setup_rx && link_in.setup_dir_in) |=>
      control_data_direction;
  endproperty
  a_dir_in: assert property (p_dir_in)
    else $error("direction not set for in");

  property p_clear;
    clr_wr |=>
      ((endpoint_flag_status & $past(clr_req) &
        ~$past(link_in.flag_set)) == `EP_ZERO8) &&
      (($past(flags_q) & ~$past(clr_req) &
        ~endpoint_flag_status) == `EP_ZERO8);
  endproperty
  a_clear: assert property (p_clear)
    else $error("flag clear wrong");

  property p_clr_reads_zero;
    (apb_setup && !pwrite && hit_clr && state_q == APB_IDLE) |=>
      pready && prdata == `EP_ZERO32;
  endproperty
  a_clr_reads_zero: assert property (p_clr_reads_zero)
    else $error("clear register read not zero");

  property p_iso_no_clear;
    (wr_done && hit_clr && cfg_q.endpoint_kind == `EP_KIND_ISO) |=>
      ($past(flags_q) & ~endpoint_flag_status) == `EP_ZERO8;
  endproperty
  a_iso_no_clear: assert property (p_iso_no_clear)
    else $error("clear acted on isochronous endpoint");

  property p_setup_bit;
    (clr_wr && pwdata[`EP_FLAG_SETUP_RX] &&
      !link_in.flag_set[`EP_FLAG_SETUP_RX]) |=>
      !endpoint_flag_status[`EP_FLAG_SETUP_RX];
  endproperty
  a_setup_bit: assert property (p_setup_bit)
    else $error("setup flag not cleared by its bit");

  property p_set_wins;
    (link_in.flag_set & clr_req) != `EP_ZERO8 |=>
      (endpoint_flag_status & $past(link_in.flag_set)) ==
      $past(link_in.flag_set);
  endproperty
  a_set_wins: assert property (p_set_wins)
    else $error("clear beat a simultaneous set");

  property p_irq;
    (|(flags_q & irq_en_q)) |=> irq;
  endproperty
  a_irq: assert property (p_irq)
    else $error("enabled flag without interrupt");

endmodule : ep_status_top

// ### rtl/ep_status_map.svh
// register map, field positions and reset values of the endpoint block
// assumes a 32-bit apb data path and byte addresses on paddr
`ifndef EP_STATUS_MAP_SVH
`define EP_STATUS_MAP_SVH

// ----------------------------------------------------------------
// register addresses
// ----------------------------------------------------------------
`define EP_ADDR_CFG 32'h40020100
`define EP_ADDR_STATUS 32'h40020130
`define EP_ADDR_FLAG_CLEAR 32'h40020160
`define EP_ADDR_IRQ_EN 32'h400201f0

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define EP_NFLAGS 8
`define EP_FLAGS 7:0
`define EP_CFG_KIND 1:0
`define EP_CFG_DIR_IN 8
`define EP_CFG_STALL 9
`define EP_CFG_NBANK 13:12
`define EP_ST_BANK 17:16
`define EP_ST_FIFO_ACCESS_ALLOWED 18
`define EP_ST_CONTROL_DATA_DIRECTION 19

// ----------------------------------------------------------------
// flag bit indices
// ----------------------------------------------------------------
`define EP_FLAG_IN_SENT 0
`define EP_FLAG_OUT_RX 1
`define EP_FLAG_SETUP_RX 2
`define EP_FLAG_OUT_NAK 3
`define EP_FLAG_IN_NAK 4
`define EP_FLAG_OVERFLOW 5
`define EP_FLAG_STALL_SENT 6
`define EP_FLAG_SHORT_PKT 7

// ----------------------------------------------------------------
// encodings and reset values
// ----------------------------------------------------------------
`define EP_KIND_CONTROL 2'h0
`define EP_KIND_ISO 2'h1
`define EP_KIND_BULK 2'h2
`define EP_KIND_INTR 2'h3
`define EP_BANK_0 2'h0
`define EP_BANK_1 2'h1
`define EP_BANK_2 2'h2
`define EP_BANK_RSVD 2'h3
`define EP_NBANK_RST 2'h1
`define EP_ZERO32 32'h00000000
`define EP_ZERO8 8'h00

`endif

// ### rtl/ep_status_pkg.sv
// types shared by the endpoint status block
// assumes ep_status_map.svh for widths
`include "ep_status_map.svh"

package ep_status_pkg;

  // ----------------------------------------------------------------
  // link side events from the usb engine
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [`EP_NFLAGS-1:0] flag_set;
    logic setup_rx;
    logic setup_dir_in;
    logic bank_room;
    logic bank_data;
    logic error;
    logic bank_switch;
  } link_evt_t;

  // ----------------------------------------------------------------
  // endpoint configuration
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [1:0] endpoint_kind;
    logic dir_in;
    logic stall_handshake_request;
    logic [1:0] nbank;
  } ep_cfg_t;

  // ----------------------------------------------------------------
  // apb slave states
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    APB_IDLE = 2'b01,
    APB_RESP = 2'b10
  } apb_state_t;

endpackage : ep_status_pkg

// ### rtl/ep_flag_bank.sv
// sticky endpoint flags, one per bit
// assumes set and clear are one-cycle pulses in the pclk domain
`timescale 1ns/1ps

module ep_flag_bank #(
  parameter int W = 8
) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // set and clear pulses
  input wire logic [W-1:0] set_evt,
  input wire logic [W-1:0] clr_req,
  // flag state
  output logic [W-1:0] flags_q
);

  // ----------------------------------------------------------------
  // per-bit sticky flag, set beats clear
  // ----------------------------------------------------------------
  genvar i;
  generate
    for (i = 0; i < W; i++) begin : g_flag
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          flags_q[i] <= 1'b0;
        end else if (set_evt[i]) begin
          flags_q[i] <= 1'b1;
        end else if (clr_req[i]) begin
          flags_q[i] <= 1'b0;
        end
      end
    end
  endgenerate

endmodule : ep_flag_bank

// ### tb/usb_host_model.sv
// usb engine and host stand-in that drives the link event struct
// assumes bench calls its tasks; changes land just after pclk rises
`timescale 1ns/1ps

module usb_host_model
  import ep_status_pkg::*;
(
  // clock
  input wire logic pclk,
  // link events
  output link_evt_t link_in
);
  link_evt_t ev_q;
  assign link_in = ev_q;
  initial ev_q = '0;

  // ----------------------------------------------------------------
  // event tasks
  // ----------------------------------------------------------------
  task flags(input logic [7:0] m);
    @(posedge pclk);
    ev_q.flag_set <= m;
    @(posedge pclk);
    ev_q.flag_set <= 8'h00;
  endtask : flags

  // setup token with its data stage direction in the same cycle
  task setup(input logic dir_in);
    @(posedge pclk);
    ev_q.setup_rx <= 1'b1;
    ev_q.setup_dir_in <= dir_in;
    @(posedge pclk);
    ev_q.setup_rx <= 1'b0;
    ev_q.setup_dir_in <= ~dir_in;
  endtask : setup

  task levels(input logic room, data, err);
    @(posedge pclk);
    ev_q.bank_room <= room;
    ev_q.bank_data <= data;
    ev_q.error <= err;
  endtask : levels

  task switch_bank();
    @(posedge pclk);
    ev_q.bank_switch <= 1'b1;
    @(posedge pclk);
    ev_q.bank_switch <= 1'b0;
  endtask : switch_bank
endmodule : usb_host_model

// ### tb/usb_device_endpoint_status_clear_tb.sv
// self-checking bench of the endpoint status and flag clear block
// assumes an apb master per protocol and the host model on the link
`timescale 1ns/1ps
`include "ep_status_map.svh"

module usb_device_endpoint_status_clear_tb
  import ep_status_pkg::*;
();
  // ----------------------------------------------------------------
  // signals
  // ----------------------------------------------------------------
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, irq;
  logic [31:0] paddr, pwdata, prdata, rd;
  logic er, fifo_access_allowed, control_data_direction;
  logic [7:0] endpoint_flag_status;
  logic [1:0] current_bank_index;
  link_evt_t link_in;
  int bad_count, comparisons, cycles;
  typedef struct packed {
    logic w; logic [31:0] a; logic [31:0] d; logic [31:0] r; logic e;
  } row_t;
  typedef struct packed {
    logic [31:0] cfg; logic room; logic data; logic err; logic exp;
  } lv_t;
  row_t rows [11] = '{
    '{1'b0, `EP_ADDR_CFG, 32'h0, 32'h00001000, 1'b0},
    '{1'b0, `EP_ADDR_STATUS, 32'h0, 32'h0, 1'b0},
    '{1'b0, `EP_ADDR_FLAG_CLEAR, 32'h0, 32'h0, 1'b0},
    '{1'b1, `EP_ADDR_FLAG_CLEAR, 32'hffffffff, 32'h0, 1'b0},
    '{1'b0, `EP_ADDR_FLAG_CLEAR, 32'h0, 32'h0, 1'b0},
    '{1'b0, 32'h40020104, 32'h0, 32'h0, 1'b1},
    '{1'b1, 32'h40020104, 32'h5a, 32'h0, 1'b1},
    '{1'b1, `EP_ADDR_STATUS, 32'hff, 32'h0, 1'b0},
    '{1'b0, `EP_ADDR_STATUS, 32'h0, 32'h0, 1'b0},
    '{1'b1, `EP_ADDR_IRQ_EN, 32'hff, 32'h0, 1'b0},
    '{1'b0, `EP_ADDR_IRQ_EN, 32'h0, 32'hff, 1'b0}};
  lv_t lvs [6] = '{
    '{32'h1102, 1'b1, 1'b0, 1'b0, 1'b1}, '{32'h1102, 1'b0, 1'b1, 1'b0, 1'b0},
    '{32'h1002, 1'b0, 1'b1, 1'b0, 1'b1}, '{32'h1002, 1'b1, 1'b0, 1'b0, 1'b0},
    '{32'h1002, 1'b0, 1'b1, 1'b1, 1'b0}, '{32'h1302, 1'b1, 1'b0, 1'b0, 1'b0}};

  ep_status_top DUT (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .link_in(link_in), .endpoint_flag_status(endpoint_flag_status),
    .current_bank_index(current_bank_index),
    .fifo_access_allowed(fifo_access_allowed),
    .control_data_direction(control_data_direction), .irq(irq));
  usb_host_model model (.pclk(pclk), .link_in(link_in));

  // ----------------------------------------------------------------
  // tasks
  // ----------------------------------------------------------------
  task chk(input logic [31:0] got, exp, input string m);
    comparisons++;
    if (got !== exp) begin
      bad_count++;
      $display("CHECK FAILED at %0t: %s got %h exp %h", $time, m, got, exp);
    end
  endtask : chk

  task apb(input logic w, input logic [31:0] a, d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // sample pready at each rising edge until it is high; the bench timeout ends this if it never is
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task wait_n(input int n);
    repeat (n) @(posedge pclk);
    @(negedge pclk);
  endtask : wait_n

  task print_verdict();
    $display("counts: %0d mismatches, %0d comparisons", bad_count,
      comparisons);
    if (bad_count == 0 && comparisons > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : print_verdict

  // ----------------------------------------------------------------
  // clock and timeout
  // ----------------------------------------------------------------
  initial begin
    pclk = 1'b0;
    forever #2.5 pclk = ~pclk;
  end
  always @(posedge pclk) begin
    cycles++;
    if (cycles == 20000) begin
      bad_count++;
      $display("CHECK FAILED at %0t: run too long", $time);
      print_verdict();
    end
  end

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    foreach (rows[i]) begin
      apb(rows[i].w, rows[i].a, rows[i].d);
      if (!rows[i].w) chk(rd, rows[i].r, "register read");
      chk(32'(er), 32'(rows[i].e), "slave error");
    end
    $display("test register table done");
    foreach (lvs[i]) begin
      apb(1'b1, `EP_ADDR_CFG, lvs[i].cfg);
      model.levels(lvs[i].room, lvs[i].data, lvs[i].err);
      wait_n(1);
      chk(32'(fifo_access_allowed), 32'(lvs[i].exp), "access");
    end
    $display("test fifo access done");
    apb(1'b1, `EP_ADDR_CFG, 32'h3002);
    for (int i = 0; i < 4; i++) begin
      model.switch_bank();
      wait_n(2);
      chk(32'(current_bank_index), 32'((i + 1) % 3), "bank");
    end
    apb(1'b1, `EP_ADDR_CFG, 32'h3000);
    model.switch_bank();
    wait_n(2);
    chk(32'(current_bank_index), 32'h0, "control bank");
    for (int d = 1; d >= 0; d--) begin
      model.setup(d[0]);
      wait_n(1);
      chk(32'(control_data_direction), 32'(d), "direction");
    end
    $display("test bank and direction done");
    model.flags(8'hff);
    wait_n(1);
    chk(32'(endpoint_flag_status), 32'hff, "flags set");
    wait_n(1);
    chk(32'(irq), 32'h1, "irq up");
    for (int i = 0; i < 8; i++) begin
      apb(1'b1, `EP_ADDR_FLAG_CLEAR, 32'h1 << i);
      wait_n(0);
      chk(32'(endpoint_flag_status), 32'(8'(8'hff << (i + 1))), "clr");
    end
    wait_n(1);
    chk(32'(irq), 32'h0, "irq down");
    apb(1'b1, `EP_ADDR_IRQ_EN, 32'h80);
    model.flags(8'h01);
    wait_n(2);
    chk(32'(irq), 32'h0, "irq masked");
    model.flags(8'h80);
    wait_n(2);
    chk(32'(irq), 32'h1, "irq enabled");
    apb(1'b1, `EP_ADDR_FLAG_CLEAR, 32'h81);
    wait_n(1);
    chk(32'(irq), 32'h0, "irq cleared");
    $display("test flags and irq done");
    fork
      apb(1'b1, `EP_ADDR_FLAG_CLEAR, 32'h2);
      begin
        @(posedge pclk);
        model.flags(8'h02);
      end
    join
    wait_n(0);
    chk(32'(endpoint_flag_status[1]), 32'h1, "set beats clear");
    apb(1'b1, `EP_ADDR_CFG, 32'h1001);
    apb(1'b1, `EP_ADDR_FLAG_CLEAR, 32'h2);
    wait_n(0);
    chk(32'(endpoint_flag_status[1]), 32'h1, "iso clear");
    apb(1'b1, `EP_ADDR_CFG, 32'h1002);
    apb(1'b1, `EP_ADDR_FLAG_CLEAR, 32'h2);
    wait_n(0);
    chk(32'(endpoint_flag_status[1]), 32'h0, "bulk clear");
    $display("test clear priority and kind done");
    model.setup(1'b1);
    model.flags(8'h01);
    @(posedge pclk);
    presetn <= 1'b0;
    wait_n(1);
    chk(32'({endpoint_flag_status, current_bank_index, irq, pready,
      fifo_access_allowed, control_data_direction}), 32'h0, "reset");
    @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, `EP_ADDR_CFG, 32'h0);
    chk(rd, 32'h00001000, "cfg after reset");
    apb(1'b0, `EP_ADDR_IRQ_EN, 32'h0);
    chk(rd, 32'h0, "irq enable after reset");
    $display("test mid-run reset done");
    print_verdict();
  end
endmodule : usb_device_endpoint_status_clear_tb
